// [rtl/kmc_pkg.sv]
// Constants, types and small decode functions for the keypad menu controller.
// Assumes a 50 MHz system clock and a synchronous, active-low reset.
package kmc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ     = 50_000_000;
	localparam int HOLD_MS    = 2000;
	localparam int TOUT_MS    = 10000;
	localparam int DEB_MS     = 10;
	localparam int BLINK_MS   = 500;
	localparam int HOLD_CYC   = CLK_HZ / 1000 * HOLD_MS;
	localparam int TOUT_CYC   = CLK_HZ / 1000 * TOUT_MS;
	localparam int DEB_CYC    = CLK_HZ / 1000 * DEB_MS;
	localparam int BLINK_CYC  = CLK_HZ / 1000 * BLINK_MS;
	localparam int CNT_W      = 30;

	// ----------------------------------------------------------------
	// Keys, menus, digits, display
	// ----------------------------------------------------------------
	localparam int NKEY       = 4;
	localparam int KEY_SETUP  = 0;
	localparam int KEY_UP     = 1;
	localparam int KEY_DOWN   = 2;
	localparam int KEY_ENTER  = 3;
	localparam int NDIG       = 6;
	localparam logic [2:0] NMENU_LAST = 3'h6;
	localparam logic [2:0] MENU_RST   = 3'h0;
	localparam logic [3:0] PARAM_RST  = 4'h0;
	localparam logic [2:0] CUR_RST    = 3'h0;
	localparam logic [2:0] CUR_LAST   = 3'h5;
	localparam logic [23:0] EDIT_RST  = 24'h000000;
	localparam int DISP_ROWS  = 2;
	localparam int DISP_COLS  = 16;
	localparam logic [3:0] DIG_COL    = 4'hA;
	localparam logic [3:0] COL_STATE  = 4'h0;
	localparam logic [3:0] COL_MENU   = 4'h2;
	localparam logic [3:0] COL_PTENS  = 4'h4;
	localparam logic [3:0] COL_PONES  = 4'h5;

	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_PLUS  = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_N     = 8'h4E;
	localparam logic [7:0] CH_M     = 8'h4D;
	localparam logic [7:0] CH_C     = 8'h43;
	localparam logic [7:0] CH_P     = 8'h50;
	localparam logic [7:0] CH_S     = 8'h53;

	// ----------------------------------------------------------------
	// Interlock levels and states
	// ----------------------------------------------------------------
	localparam logic [1:0] LATCH_NONE  = 2'h0;
	localparam logic [1:0] LATCH_PARAM = 2'h1;
	localparam logic [1:0] LATCH_ALL   = 2'h2;

	typedef enum logic [2:0] {ST_NORMAL, ST_MENU, ST_PASS, ST_PARAM, ST_SETTING} kmc_state_e;

	// Parameter count of each menu, minus one
	function automatic logic [3:0] kmc_param_last(input logic [2:0] m);
		unique case (m)
			3'h0:    kmc_param_last = 4'h1;
			3'h1:    kmc_param_last = 4'h4;
			3'h2:    kmc_param_last = 4'h4;
			3'h3:    kmc_param_last = 4'h6;
			3'h4:    kmc_param_last = 4'hA;
			3'h5:    kmc_param_last = 4'h5;
			default: kmc_param_last = 4'h0;
		endcase
	endfunction

	// One decimal digit up or down, wrapping 0..9 without carry
	function automatic logic [3:0] kmc_digit_step(input logic [3:0] d, input logic up);
		if (up)
			kmc_digit_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
		else
			kmc_digit_step = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
	endfunction

endpackage

// [rtl/kmc_key_filter.sv]
// Debounce filter for the four front keys.
// Assumes raw key levels active high and synchronous to clk_i.
`timescale 1ns/1ps
module kmc_key_filter #(
	parameter int DEB_CYCLES = kmc_pkg::DEB_CYC
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_b_i,
	input  wire logic [kmc_pkg::NKEY-1:0] key_i,
	output wire logic [kmc_pkg::NKEY-1:0] level_o,
	output wire logic [kmc_pkg::NKEY-1:0] press_o
);

	// ----------------------------------------------------------------
	// One filter per key
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < kmc_pkg::NKEY; g++) begin : g_key
			logic [kmc_pkg::CNT_W-1:0] cnt_r;
			logic                      stable_r;
			logic                      press_r;

			always_ff @(posedge clk_i) begin
				if (!rst_b_i) begin
					cnt_r    <= '0;
					stable_r <= 1'b0;
					press_r  <= 1'b0;
				end else begin
					press_r <= 1'b0;
					if (key_i[g] == stable_r) begin
						cnt_r <= '0;
					end else if (cnt_r == kmc_pkg::CNT_W'(DEB_CYCLES - 1)) begin
						cnt_r    <= '0;
						stable_r <= key_i[g];
						press_r  <= key_i[g]; // [RQ21]
					end else begin
						cnt_r <= cnt_r + kmc_pkg::CNT_W'(1);
					end
				end
			end

			assign level_o[g] = stable_r;
			assign press_o[g] = press_r;
		end
	endgenerate

endmodule // kmc_key_filter

// [rtl/kmc_lcd_feed.sv]
// Refresh of a two-row, sixteen-column character display.
// Assumes a display port that takes one character per write strobe.
`timescale 1ns/1ps
module kmc_lcd_feed #(
	parameter int BLINK_CYCLES = kmc_pkg::BLINK_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  kmc_pkg::kmc_state_e      state_i,
	input  wire logic [2:0]          menu_i,
	input  wire logic [3:0]          param_i,
	input  wire logic [23:0]         value_i,
	input  wire logic [2:0]          cursor_i,
	input  wire logic                signed_i,
	input  wire logic                blink_en_i,
	output logic      [4:0]          lcd_pos_o,
	output logic      [7:0]          lcd_char_o,
	output logic                     lcd_we_o
);

	logic [4:0]                pos_r;
	logic [kmc_pkg::CNT_W-1:0] blink_cnt_r;
	logic                      blink_r;
	logic [3:0]                col;
	logic [2:0]                idx;
	logic [3:0]                dig;
	logic [7:0]                ch;

	// ----------------------------------------------------------------
	// Scan position and blink phase
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r == kmc_pkg::CNT_W'(BLINK_CYCLES - 1)) begin
			blink_cnt_r <= '0;
			blink_r     <= ~blink_r; // [RQ16]
		end else begin
			blink_cnt_r <= blink_cnt_r + kmc_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pos_r      <= 5'h00;
			lcd_pos_o  <= 5'h00;
			lcd_char_o <= kmc_pkg::CH_SPACE;
			lcd_we_o   <= 1'b0;
		end else begin
			pos_r      <= pos_r + 5'h01;
			lcd_pos_o  <= pos_r;
			lcd_char_o <= ch;
			lcd_we_o   <= 1'b1; // [RQ1]
		end
	end

	// ----------------------------------------------------------------
	// Character at the scan position
	// ----------------------------------------------------------------
	always_comb begin
		col = pos_r[3:0];
		idx = 3'(4'hF - col);
		dig = value_i[{idx, 2'b00} +: 4];
		ch  = kmc_pkg::CH_SPACE;
		if (!pos_r[4]) begin
			if (col == kmc_pkg::COL_STATE) begin
				unique case (state_i)
					kmc_pkg::ST_NORMAL:  ch = kmc_pkg::CH_N;
					kmc_pkg::ST_MENU:    ch = kmc_pkg::CH_M;
					kmc_pkg::ST_PASS:    ch = kmc_pkg::CH_C;
					kmc_pkg::ST_PARAM:   ch = kmc_pkg::CH_P;
					kmc_pkg::ST_SETTING: ch = kmc_pkg::CH_S;
				endcase
			end else if (col == kmc_pkg::COL_MENU) begin
				ch = kmc_pkg::CH_ZERO + {5'h00, menu_i};
			end else if (col == kmc_pkg::COL_PTENS) begin
				ch = kmc_pkg::CH_ZERO + {7'h00, (param_i > 4'h9)};
			end else if (col == kmc_pkg::COL_PONES) begin
				ch = kmc_pkg::CH_ZERO + {4'h0, (param_i > 4'h9) ? param_i - 4'hA : param_i};
			end
		end else if (col >= kmc_pkg::DIG_COL) begin
			ch = kmc_pkg::CH_ZERO + {4'h0, dig}; // [RQ1]
			if (signed_i && idx == kmc_pkg::CUR_LAST)
				ch = dig[0] ? kmc_pkg::CH_MINUS : kmc_pkg::CH_PLUS; // [RQ15]
			if (blink_en_i && blink_r && idx == cursor_i)
				ch = kmc_pkg::CH_SPACE; // [RQ16]
		end
	end

endmodule // kmc_lcd_feed

// [rtl/kmc_keypad_menu.sv]
// Front-panel keypad and setup menu controller.
// Assumes a parameter store that answers combinationally on par_* inputs.
`timescale 1ns/1ps
// Behaviour
// RQ1 - Drive two-row sixteen-character display with menus, status
// RQ2 - Key meaning depends on normal or setup state
// RQ3 - Normal keys fire their configured command functions
// RQ4 - Three protection stages: none, password, hardware latch
// RQ5 - Separate password held for each parameter group
// RQ6 - Protected group asks for its password first
// RQ7 - Password not done in time: refuse, go normal
// RQ8 - Latch by input or register; level 1/2
// RQ9 - Setup entered after setup key held two seconds
// RQ10 - Menu level: save/exit, next, previous, descend
// RQ11 - Parameter level: back, next, previous, descend
// RQ12 - Setting level: validate, store, return to parameters
// RQ13 - Setting level: up/down change digit under cursor
// RQ14 - Enter moves cursor left, wraps to rightmost
// RQ15 - Signed leading digit toggles plus and minus only
// RQ16 - Cursor digit blinks, starts at rightmost digit
// RQ17 - Setup key steps one level back
// RQ18 - Ten seconds idle steps back, restarts count
// RQ19 - Factory default restore for all parameters, passwords
// RQ20 - Control inputs held at least two milliseconds; lock_in_i is used with no hold filter
// RQ21 - Each key debounced into one press event
// RQ22 - Digit steps wrap zero to nine, no carry
module kmc_keypad_menu #(
	parameter int HOLD_CYCLES  = kmc_pkg::HOLD_CYC,
	parameter int TOUT_CYCLES  = kmc_pkg::TOUT_CYC,
	parameter int DEB_CYCLES   = kmc_pkg::DEB_CYC,
	parameter int BLINK_CYCLES = kmc_pkg::BLINK_CYC
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_b_i,
	input  wire logic [kmc_pkg::NKEY-1:0] key_raw_i,
	input  wire logic                     lock_in_i,
	input  wire logic                     lock_pol_i,
	input  wire logic [1:0]               lock_in_lvl_i,
	input  wire logic [1:0]               lock_reg_i,
	input  wire logic [23:0]              par_value_i,
	input  wire logic                     par_signed_i,
	input  wire logic                     par_select_i,
	input  wire logic                     par_ok_i,
	input  wire logic [6:0]               grp_prot_i,
	input  wire logic [23:0]              grp_pwd_i,
	input  wire logic [23:0]              status_i,
	output logic                          cmd_go_o,
	output logic      [1:0]               cmd_key_o,
	output logic      [2:0]               menu_o,
	output logic      [3:0]               param_o,
	output logic                          par_wr_o,
	output logic      [23:0]              par_wdata_o,
	output logic                          save_o,
	output logic                          dflt_o,
	output logic                          setup_o,
	output logic                          entry_err_o,
	output logic      [4:0]               lcd_pos_o,
	output logic      [7:0]               lcd_char_o,
	output logic                          lcd_we_o
);

	logic [kmc_pkg::NKEY-1:0]  key_lvl;
	logic [kmc_pkg::NKEY-1:0]  key_prs;
	logic [kmc_pkg::NKEY-1:0]  key_ev;
	kmc_pkg::kmc_state_e       state_r;
	kmc_pkg::kmc_state_e       state_nxt;
	logic [2:0]                menu_nxt;
	logic [3:0]                param_nxt;
	logic [2:0]                cur_r;
	logic [2:0]                cur_nxt;
	logic [23:0]               edit_r;
	logic [23:0]               edit_nxt;
	logic [1:0]                latch_r;
	logic [1:0]                lvl_in;
	logic [kmc_pkg::CNT_W-1:0] hold_cnt_r;
	logic [kmc_pkg::CNT_W-1:0] dflt_cnt_r;
	logic [kmc_pkg::CNT_W-1:0] tout_cnt_r;
	logic                      hold_hit;
	logic                      dflt_hit;
	logic                      tout_hit;
	logic                      cmd_go_nxt;
	logic [1:0]                cmd_key_nxt;
	logic                      par_wr_nxt;
	logic                      save_nxt;
	logic                      err_nxt;
	logic [23:0]               disp_val;

	// Apply one up/down step to the digit under the cursor
	function automatic logic [23:0] kmc_edit(input logic [23:0] v, input logic [2:0] c,
		input logic up, input logic sgn);
		logic [23:0] r;
		r = v;
		for (int i = 0; i < kmc_pkg::NDIG; i++) begin
			if (c == 3'(i)) begin
				if (sgn && c == kmc_pkg::CUR_LAST)
					r[i*4 +: 4] = {3'h0, ~v[i*4]}; // [RQ15]
				else
					r[i*4 +: 4] = kmc_pkg::kmc_digit_step(v[i*4 +: 4], up); // [RQ13] [RQ22]
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Key filtering
	// ----------------------------------------------------------------
	kmc_key_filter #(
		.DEB_CYCLES (DEB_CYCLES)
	) u_keys (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.key_i   (key_raw_i),
		.level_o (key_lvl),
		.press_o (key_prs)
	);

	// ----------------------------------------------------------------
	// Interlock level
	// ----------------------------------------------------------------
	// Control input is taken as held long enough by the driver [RQ20]
	assign lvl_in = (lock_in_i == lock_pol_i) ? lock_in_lvl_i : kmc_pkg::LATCH_NONE;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			latch_r <= kmc_pkg::LATCH_NONE;
		else
			latch_r <= (lvl_in > lock_reg_i) ? lvl_in : lock_reg_i; // [RQ8]
	end

	assign key_ev = (latch_r >= kmc_pkg::LATCH_ALL) ? '0 : key_prs; // [RQ8] [RQ4]

	// ----------------------------------------------------------------
	// Hold, default and idle timers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !key_lvl[kmc_pkg::KEY_SETUP])
			hold_cnt_r <= '0;
		else if (hold_cnt_r != kmc_pkg::CNT_W'(HOLD_CYCLES))
			hold_cnt_r <= hold_cnt_r + kmc_pkg::CNT_W'(1);
	end
	assign hold_hit = (hold_cnt_r == kmc_pkg::CNT_W'(HOLD_CYCLES - 1)); // [RQ9]

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !(key_lvl[kmc_pkg::KEY_UP] && key_lvl[kmc_pkg::KEY_DOWN]))
			dflt_cnt_r <= '0;
		else if (dflt_cnt_r != kmc_pkg::CNT_W'(HOLD_CYCLES))
			dflt_cnt_r <= dflt_cnt_r + kmc_pkg::CNT_W'(1);
	end
	assign dflt_hit = (dflt_cnt_r == kmc_pkg::CNT_W'(HOLD_CYCLES - 1)); // [RQ19]

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || state_r == kmc_pkg::ST_NORMAL || |key_ev || tout_hit)
			tout_cnt_r <= '0; // [RQ18]
		else
			tout_cnt_r <= tout_cnt_r + kmc_pkg::CNT_W'(1);
	end
	assign tout_hit = (tout_cnt_r == kmc_pkg::CNT_W'(TOUT_CYCLES - 1));

	// ----------------------------------------------------------------
	// Menu state decode
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt   = state_r;
		menu_nxt    = menu_o;
		param_nxt   = param_o;
		cur_nxt     = cur_r;
		edit_nxt    = edit_r;
		cmd_go_nxt  = 1'b0;
		cmd_key_nxt = cmd_key_o;
		par_wr_nxt  = 1'b0;
		save_nxt    = 1'b0;
		err_nxt     = 1'b0;
		unique case (state_r) // [RQ2]
			kmc_pkg::ST_NORMAL: begin
				if (hold_hit && latch_r == kmc_pkg::LATCH_NONE) begin
					state_nxt = kmc_pkg::ST_MENU; // [RQ9]
					menu_nxt  = kmc_pkg::MENU_RST;
				end else if (|key_ev[kmc_pkg::KEY_ENTER:kmc_pkg::KEY_UP]) begin
					cmd_go_nxt = 1'b1; // [RQ3]
					if (key_ev[kmc_pkg::KEY_UP])
						cmd_key_nxt = 2'h1;
					else if (key_ev[kmc_pkg::KEY_DOWN])
						cmd_key_nxt = 2'h2;
					else
						cmd_key_nxt = 2'h3;
				end
			end
			kmc_pkg::ST_MENU: begin
				if (key_ev[kmc_pkg::KEY_SETUP] || tout_hit) begin
					state_nxt = kmc_pkg::ST_NORMAL; // [RQ10] [RQ17] [RQ18]
					save_nxt  = 1'b1;
				end else if (key_ev[kmc_pkg::KEY_UP]) begin
					menu_nxt = (menu_o == kmc_pkg::NMENU_LAST) ? 3'h0 : menu_o + 3'h1; // [RQ10]
				end else if (key_ev[kmc_pkg::KEY_DOWN]) begin
					menu_nxt = (menu_o == 3'h0) ? kmc_pkg::NMENU_LAST : menu_o - 3'h1; // [RQ10]
				end else if (key_ev[kmc_pkg::KEY_ENTER]) begin
					param_nxt = kmc_pkg::PARAM_RST;
					if (grp_prot_i[menu_o]) begin
						state_nxt = kmc_pkg::ST_PASS; // [RQ6] [RQ4]
						edit_nxt  = kmc_pkg::EDIT_RST;
						cur_nxt   = kmc_pkg::CUR_RST;
					end else begin
						state_nxt = kmc_pkg::ST_PARAM; // [RQ10]
					end
				end
			end
			kmc_pkg::ST_PASS: begin
				if (key_ev[kmc_pkg::KEY_SETUP]) begin
					if (edit_r == grp_pwd_i) begin
						state_nxt = kmc_pkg::ST_PARAM; // [RQ5] [RQ6]
					end else begin
						state_nxt = kmc_pkg::ST_NORMAL; // [RQ7]
						err_nxt   = 1'b1;
					end
				end else if (key_ev[kmc_pkg::KEY_UP] || key_ev[kmc_pkg::KEY_DOWN]) begin
					edit_nxt = kmc_edit(edit_r, cur_r, key_ev[kmc_pkg::KEY_UP], 1'b0);
				end else if (key_ev[kmc_pkg::KEY_ENTER]) begin
					cur_nxt = (cur_r == kmc_pkg::CUR_LAST) ? 3'h0 : cur_r + 3'h1;
				end else if (tout_hit) begin
					state_nxt = kmc_pkg::ST_NORMAL; // [RQ7]
					err_nxt   = 1'b1;
				end
			end
			kmc_pkg::ST_PARAM: begin
				if (key_ev[kmc_pkg::KEY_SETUP] || tout_hit) begin
					state_nxt = kmc_pkg::ST_MENU; // [RQ11] [RQ17] [RQ18]
				end else if (key_ev[kmc_pkg::KEY_UP]) begin
					param_nxt = (param_o == kmc_pkg::kmc_param_last(menu_o)) ? 4'h0
						: param_o + 4'h1; // [RQ11]
				end else if (key_ev[kmc_pkg::KEY_DOWN]) begin
					param_nxt = (param_o == 4'h0) ? kmc_pkg::kmc_param_last(menu_o)
						: param_o - 4'h1; // [RQ11]
				end else if (key_ev[kmc_pkg::KEY_ENTER]) begin
					state_nxt = kmc_pkg::ST_SETTING; // [RQ11]
					edit_nxt  = par_value_i;
					cur_nxt   = kmc_pkg::CUR_RST; // [RQ16]
				end
			end
			kmc_pkg::ST_SETTING: begin
				if (key_ev[kmc_pkg::KEY_SETUP]) begin
					state_nxt  = kmc_pkg::ST_PARAM; // [RQ12] [RQ17]
					par_wr_nxt = par_ok_i;
					err_nxt    = ~par_ok_i;
				end else if (key_ev[kmc_pkg::KEY_UP] || key_ev[kmc_pkg::KEY_DOWN]) begin
					edit_nxt = kmc_edit(edit_r, cur_r, key_ev[kmc_pkg::KEY_UP],
						par_signed_i && !par_select_i); // [RQ13]
				end else if (key_ev[kmc_pkg::KEY_ENTER] && !par_select_i) begin
					cur_nxt = (cur_r == kmc_pkg::CUR_LAST) ? 3'h0 : cur_r + 3'h1; // [RQ14]
				end else if (tout_hit) begin
					state_nxt = kmc_pkg::ST_PARAM; // [RQ18]
				end
			end
		endcase
		if (state_r != kmc_pkg::ST_NORMAL && latch_r != kmc_pkg::LATCH_NONE) begin
			state_nxt  = kmc_pkg::ST_NORMAL; // [RQ8]
			par_wr_nxt = 1'b0;
		end
		if (dflt_hit)
			state_nxt = kmc_pkg::ST_NORMAL; // [RQ19]
	end

	// ----------------------------------------------------------------
	// State, position and edit registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_r <= kmc_pkg::ST_NORMAL;
			setup_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			setup_o <= (state_nxt != kmc_pkg::ST_NORMAL);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			menu_o  <= kmc_pkg::MENU_RST;
			param_o <= kmc_pkg::PARAM_RST;
		end else begin
			menu_o  <= menu_nxt;
			param_o <= param_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cur_r  <= kmc_pkg::CUR_RST;
			edit_r <= kmc_pkg::EDIT_RST;
		end else begin
			cur_r  <= cur_nxt;
			edit_r <= edit_nxt;
		end
	end

	assign par_wdata_o = edit_r;

	// ----------------------------------------------------------------
	// Event pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cmd_go_o    <= 1'b0;
			cmd_key_o   <= 2'h0;
			par_wr_o    <= 1'b0;
			save_o      <= 1'b0;
			dflt_o      <= 1'b0;
			entry_err_o <= 1'b0;
		end else begin
			cmd_go_o    <= cmd_go_nxt;
			cmd_key_o   <= cmd_key_nxt;
			par_wr_o    <= par_wr_nxt; // [RQ12]
			save_o      <= save_nxt;
			dflt_o      <= dflt_hit; // [RQ19]
			entry_err_o <= err_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Display
	// ----------------------------------------------------------------
	always_comb begin
		if (state_r == kmc_pkg::ST_SETTING || state_r == kmc_pkg::ST_PASS)
			disp_val = edit_r;
		else if (state_r == kmc_pkg::ST_NORMAL)
			disp_val = status_i;
		else
			disp_val = par_value_i;
	end

	kmc_lcd_feed #(
		.BLINK_CYCLES (BLINK_CYCLES)
	) u_lcd (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.state_i    (state_r),
		.menu_i     (menu_o),
		.param_i    (param_o),
		.value_i    (disp_val),
		.cursor_i   (cur_r),
		.signed_i   (state_r == kmc_pkg::ST_SETTING && par_signed_i),
		.blink_en_i (state_r == kmc_pkg::ST_SETTING || state_r == kmc_pkg::ST_PASS),
		.lcd_pos_o  (lcd_pos_o),
		.lcd_char_o (lcd_char_o),
		.lcd_we_o   (lcd_we_o)
	);

endmodule // kmc_keypad_menu

// [verification/kmc_menu_sva.sv]
// Assertions on the keypad menu controller ports.
// Assumes one clock domain and a bind into kmc_keypad_menu.
`timescale 1ns/1ps
module kmc_menu_sva #(
	parameter int HOLD_CYCLES = kmc_pkg::HOLD_CYC
) (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic [3:0] key_raw_i,
	input wire logic [1:0] lock_reg_i,
	input wire logic       cmd_go_o,
	input wire logic [2:0] menu_o,
	input wire logic       par_wr_o,
	input wire logic       save_o,
	input wire logic       dflt_o,
	input wire logic       setup_o,
	input wire logic       entry_err_o,
	input wire logic [4:0] lcd_pos_o,
	input wire logic       lcd_we_o
);
	// ------------------------------------------------
	// Setup key hold counter
	// ------------------------------------------------
	int unsigned held_r;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !key_raw_i[0])
			held_r <= 0;
		else
			held_r <= held_r + 1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_cmd_pulse;
		cmd_go_o ##1 !cmd_go_o;
	endsequence
	a_cmd_pulse: assert property (cmd_go_o |-> s_cmd_pulse)
		else $error("command pulse too long");
	a_setup_quiet: assert property (setup_o |-> !cmd_go_o)
		else $error("command fired in setup");
	a_lock_all: assert property ($past(lock_reg_i, 2) == 2'h2
		|-> !cmd_go_o && !par_wr_o) else $error("key acted under full latch");
	a_lock_exit: assert property ($past(lock_reg_i, 2) != 2'h0 |-> !setup_o)
		else $error("setup kept under latch");
	a_setup_hold: assert property ($rose(setup_o) |-> held_r >= HOLD_CYCLES && menu_o == 3'h0)
		else $error("setup entered too early");
	a_wr_stay: assert property (par_wr_o |-> setup_o && !entry_err_o)
		else $error("store left setup");
	a_save_exit: assert property (save_o |-> !setup_o && $past(setup_o))
		else $error("save without exit");
	a_dflt_norm: assert property (dflt_o |-> !setup_o && !par_wr_o)
		else $error("default restore in setup");
	a_lcd_scan: assert property (lcd_we_o && $past(lcd_we_o)
		|-> lcd_pos_o == 5'($past(lcd_pos_o) + 5'h1)) else $error("display scan skipped");
endmodule // kmc_menu_sva

bind kmc_keypad_menu kmc_menu_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_kmc_menu_sva (.clk_i, .rst_b_i,
	.key_raw_i, .lock_reg_i, .cmd_go_o, .menu_o, .par_wr_o, .save_o, .dflt_o, .setup_o,
	.entry_err_o, .lcd_pos_o, .lcd_we_o);

// [verification/kmc_operator.sv]
// Operator model: holds the requested keys for a number of cycles.
// Assumes requests are raised by the bench after a falling edge.
`timescale 1ns/1ps
module kmc_operator (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [3:0] keys_i,
	input  wire logic [7:0] len_i,
	output logic      [3:0] key_raw_o
);
	int         left = 0;
	logic [3:0] keys_r = 4'h0;
	always @(posedge clk_i) begin
		if (go_i) begin
			left <= len_i;
			keys_r <= keys_i;
		end else if (left > 0)
			left <= left - 1;
	end
	initial key_raw_o = 4'h0;
	always @(negedge clk_i) key_raw_o <= (left > 0) ? keys_r : 4'h0;
endmodule // kmc_operator

// [verification/kmc_keypad_menu_tb.sv]
// Self-checking bench for the keypad menu controller.
// Assumes short timing parameters and the operator model on the keys.
`timescale 1ns/1ps
module kmc_keypad_menu_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  keys = 4'h0;
	logic [7:0]  len = 8'h0;
	logic [3:0]  raw;
	logic        lk_in = 1'b0;
	logic [1:0]  lk_reg = 2'h0;
	logic [23:0] val = 24'h001029;
	logic [6:0]  prot = 7'h00;
	logic [23:0] st = 24'h000000;
	logic        pol = 1'b1;
	logic        ok = 1'b1;
	logic [23:0] pwd = 24'h000001;
	logic [4:0]  lpos;
	logic [7:0]  lch;
	logic        cgo, wr, sv, df, su, er, we;
	logic [1:0]  ckey;
	logic [2:0]  menu;
	logic [3:0]  param;
	logic [23:0] wdata;
	int          n_mismatch = 0, comparisons = 0, seed = 25, n_go = 0, n_wr = 0, n_sv = 0;
	int          n_df = 0, n_er = 0, cur, dig[6];
	int          seq[9] = '{2, 8, 4, 8, 8, 8, 8, 8, 2};
	initial forever #10 clk = ~clk;
	kmc_operator i_kmc_operator (.clk_i(clk), .go_i(go), .keys_i(keys), .len_i(len), .key_raw_o(raw));
	kmc_keypad_menu #(.HOLD_CYCLES(20), .TOUT_CYCLES(50), .DEB_CYCLES(2), .BLINK_CYCLES(4))
	i_kmc_keypad_menu (.clk_i(clk), .rst_b_i(rst_b), .key_raw_i(raw), .lock_in_i(lk_in),
		.lock_pol_i(pol), .lock_in_lvl_i(2'h1), .lock_reg_i(lk_reg), .par_value_i(val),
		.par_signed_i(1'b0), .par_select_i(1'b0), .par_ok_i(ok), .grp_prot_i(prot),
		.grp_pwd_i(pwd), .status_i(st), .cmd_go_o(cgo), .cmd_key_o(ckey), .menu_o(menu),
		.param_o(param), .par_wr_o(wr), .par_wdata_o(wdata), .save_o(sv), .dflt_o(df),
		.setup_o(su), .entry_err_o(er), .lcd_pos_o(lpos), .lcd_char_o(lch), .lcd_we_o(we));
	always @(posedge clk) begin
		n_go += (cgo === 1'b1);
		n_wr += (wr === 1'b1);
		n_sv += (sv === 1'b1);
		n_df += (df === 1'b1);
		n_er += (er === 1'b1);
	end
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic press(input logic [3:0] k, input int n);
		@(negedge clk);
		keys = k;
		len = 8'(n);
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		repeat (n + 8) @(negedge clk);
	endtask
	task automatic wait_su(input logic e);
		int i;
		for (i = 0; i < 300 && su !== e; i++) @(negedge clk);
		if (i == 300) begin
			n_mismatch++;
			$display("Error at %0t: setup wait expired", $time);
			print_verdict();
		end
	endtask
	initial begin
		for (int i = 0; i < 6; i++) st[i*4+:4] = 4'($unsigned($random(seed)) % 10);
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		for (int k = 1; k < 4; k++) begin
			press(4'h1 << k, 3 + ($random(seed) & 3));
			chk(24'(ckey), 24'(k));
		end
		for (int i = 0; i < 40 && lpos !== 5'h1F; i++) @(negedge clk);
		chk(24'({we, lpos, lch}), 24'({1'b1, 5'h1F, 8'h30 + {4'h0, st[3:0]}}));
		press(4'h1, 6);
		chk(24'(su), 24'h0);
		chk(24'(n_go), 24'h3);
		$display("test normal keys done");
		press(4'h1, 30);
		chk(24'(su), 24'h1);
		press(4'h2, 4);
		chk(24'(menu), 24'h1);
		press(4'h4, 4);
		chk(24'(menu), 24'h0);
		press(4'h8, 4);
		press(4'h2, 4);
		chk(24'(param), 24'h1);
		press(4'h8, 4);
		cur = 0;
		for (int i = 0; i < 6; i++) dig[i] = val[i*4+:4];
		foreach (seq[j]) begin
			press(4'(seq[j]), 4);
			if (seq[j] == 2) dig[cur] = (dig[cur] + 1) % 10;
			if (seq[j] == 4) dig[cur] = (dig[cur] + 9) % 10;
			if (seq[j] == 8) cur = (cur + 1) % 6;
			chk(wdata, {4'(dig[5]), 4'(dig[4]), 4'(dig[3]), 4'(dig[2]), 4'(dig[1]), 4'(dig[0])});
		end
		ok = 1'b0;
		press(4'h1, 4);
		press(4'h8, 4);
		ok = 1'b1;
		press(4'h1, 4);
		chk(24'(n_wr * 16 + n_er), 24'h11);
		press(4'h1, 4);
		press(4'h1, 4);
		chk(24'({su, 4'(n_sv)}), 24'h01);
		$display("test menu editing done");
		press(4'h1, 30);
		press(4'h8, 4);
		wait_su(1'b0);
		repeat (2) @(negedge clk);
		chk(24'(n_sv), 24'h2);
		prot = 7'h01;
		press(4'h1, 30);
		press(4'h8, 4);
		press(4'h1, 4);
		chk(24'({su, 4'(n_er)}), 24'h02);
		press(4'h1, 30);
		press(4'h8, 4);
		press(4'h2, 4);
		press(4'h1, 4);
		chk(24'({su, param}), 24'h10);
		prot = 7'h00;
		$display("test timeout and password done");
		press(4'h1, 30);
		lk_reg = 2'h2;
		press(4'h2, 4);
		chk(24'({su, 4'(n_go)}), 24'h03);
		lk_reg = 2'h0;
		lk_in = 1'b1;
		press(4'h1, 30);
		press(4'h2, 4);
		chk(24'({su, 4'(n_go)}), 24'h04);
		lk_in = 1'b0;
		press(4'h6, 30);
		chk(24'(n_df), 24'h1);
		$display("test latch and defaults done");
		print_verdict();
	end
endmodule // kmc_keypad_menu_tb
